// ---- srcd_map.vh ----
// Register map, field layout and timing constants of the sample rate clock decoder
`ifndef SRCD_MAP_VH
`define SRCD_MAP_VH
// Register indices, byte address is index times four
`define SRCD_IDX_RATES0 8'h14
`define SRCD_IDX_RATE_SEL 8'h15
`define SRCD_IDX_ENABLES 8'h16
`define SRCD_IDX_MIC_CTRL 8'h17
`define SRCD_IDX_STATUS 8'h18
// Field positions
`define SRCD_HALVE_BIT 0
`define SRCD_IDX_HI 13
`define SRCD_IDX_LO 10
`define SRCD_FAM_HI 9
`define SRCD_FAM_LO 8
`define SRCD_RATE_HI 3
`define SRCD_RATE_LO 0
`define SRCD_GATE_BIT 2
`define SRCD_DSP_BIT 1
`define SRCD_PIN_BIT 0
`define SRCD_LEFT_BIT 1
`define SRCD_RIGHT_BIT 2
// Reset values
`define SRCD_RST_IDX 4'h3
`define SRCD_RST_FAM 2'h0
`define SRCD_RST_RATE 4'h8
// Codes
`define SRCD_RATE_88K2 4'h9
`define SRCD_RATE_96K 4'hA
`define SRCD_RESP_OKAY 2'h0
`define SRCD_RESP_SLVERR 2'h2
`define SRCD_RESP_DECERR 2'h3
// Timing
`define SRCD_CLK_NS 8
`define SRCD_MCLK_LOSS_NS 2000
`define SRCD_MCLK_LOSS_CYC (`SRCD_MCLK_LOSS_NS / `SRCD_CLK_NS)
`define SRCD_MIC_MIN_HZ 1000000
`define SRCD_MIC_MAX_HZ 3000000
`define SRCD_MIC_DIV_MAX 32
`endif

// ---- srcd_top.v ----
// Sample rate decoder, core clock enable, microphone clock pin and register slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "srcd_map.vh"
module srcd_top
(
  // Clock and reset
  input wire clock_i,
  input wire reset_n_i,
  // Master clock pin
  input wire mclk_i,
  // AXI4-Lite write
  input wire s_axi_awvalid_i,
  input wire [11:0] s_axi_awaddr_i,
  output reg s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  output reg s_axi_wready_o,
  output reg s_axi_bvalid_o,
  output reg [1:0] s_axi_bresp_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read
  input wire s_axi_arvalid_i,
  input wire [11:0] s_axi_araddr_i,
  output reg s_axi_arready_o,
  output reg s_axi_rvalid_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  input wire s_axi_rready_i,
  // Clock enables and path controls
  output reg core_tick_o,
  output reg fs_tick_o,
  output reg [10:0] ratio_o,
  output reg dsp_clock_on_o,
  output reg left_filter_on_o,
  output reg right_filter_on_o,
  output reg mclk_present_o,
  // General pin one
  output reg general_pin_one_o,
  output reg general_pin_one_oe_n_o
);

////////////////////////////////////////////////////////////////////////////////
// Tables

// Ratio of core clock to fs, zero for reserved settings
function [10:0] srcd_ratio;
  input [1:0] fam;
  input [3:0] idx;
  begin
    srcd_ratio = 11'h000;
    case ({fam, idx})
      6'h00: srcd_ratio = 11'h040;
      6'h01: srcd_ratio = 11'h080;
      6'h02: srcd_ratio = 11'h0C0;
      6'h03: srcd_ratio = 11'h100;
      6'h04: srcd_ratio = 11'h180;
      6'h05: srcd_ratio = 11'h200;
      6'h06: srcd_ratio = 11'h300;
      6'h07: srcd_ratio = 11'h400;
      6'h08: srcd_ratio = 11'h580;
      6'h09: srcd_ratio = 11'h600;
      6'h10: srcd_ratio = 11'h044;
      6'h11: srcd_ratio = 11'h088;
      6'h12: srcd_ratio = 11'h0CC;
      6'h13: srcd_ratio = 11'h110;
      6'h14: srcd_ratio = 11'h198;
      6'h15: srcd_ratio = 11'h220;
      6'h16: srcd_ratio = 11'h330;
      6'h17: srcd_ratio = 11'h440;
      6'h18: srcd_ratio = 11'h5D8;
      6'h19: srcd_ratio = 11'h660;
      6'h20: srcd_ratio = 11'h07D;
      6'h21: srcd_ratio = 11'h07D;
      6'h22: srcd_ratio = 11'h0FA;
      6'h23: srcd_ratio = 11'h0FA;
      6'h24: srcd_ratio = 11'h177;
      6'h25: srcd_ratio = 11'h1F4;
      6'h26: srcd_ratio = 11'h2EE;
      6'h27: srcd_ratio = 11'h3E8;
      6'h28: srcd_ratio = 11'h3E8;
      6'h29: srcd_ratio = 11'h5DC;
      default: srcd_ratio = 11'h000;
    endcase
  end
endfunction

// Sample rate in Hz per code, zero for reserved codes
function [16:0] srcd_fs_hz;
  input [3:0] code;
  begin
    case (code)
      4'h0: srcd_fs_hz = 17'h01F40;
      4'h1: srcd_fs_hz = 17'h02B11;
      4'h2: srcd_fs_hz = 17'h02EE0;
      4'h3: srcd_fs_hz = 17'h03E80;
      4'h4: srcd_fs_hz = 17'h05622;
      4'h5: srcd_fs_hz = 17'h05DC0;
      4'h6: srcd_fs_hz = 17'h07D00;
      4'h7: srcd_fs_hz = 17'h0AC44;
      4'h8: srcd_fs_hz = 17'h0BB80;
      4'h9: srcd_fs_hz = 17'h15888;
      4'hA: srcd_fs_hz = 17'h17700;
      default: srcd_fs_hz = 17'h00000;
    endcase
  end
endfunction

// Smallest core-tick divisor giving a mic clock that divides the ratio and sits in range
function [5:0] srcd_mic_div;
  input [10:0] r;
  input [16:0] f;
  integer d;
  reg found;
  reg [31:0] hz;
  begin
    srcd_mic_div = 6'h00;
    found = 1'b0;
    hz = 32'h0;
    for (d = 2; d <= `SRCD_MIC_DIV_MAX; d = d + 1)
    begin
      hz = (r * f) / d;
      if (!found && r != 11'h000 && (r % d) == 0 && hz <= `SRCD_MIC_MAX_HZ && hz >= `SRCD_MIC_MIN_HZ)
      begin
        srcd_mic_div = d[5:0];
        found = 1'b1;
      end
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers

reg halving;
reg [3:0] ratio_index;
reg [1:0] ratio_family;
reg [3:0] rate_code;
reg core_gate;
reg dsp_gate;
reg pin_mic_sel;
reg left_on;
reg right_on;
reg [10:0] ratio;
reg [5:0] mic_div;
reg mic_rate_ok;

////////////////////////////////////////////////////////////////////////////////
// Master clock sampling and presence

reg mclk_meta;
reg mclk_sync;
reg mclk_prev;
reg mclk_phase;
reg [11:0] loss_cnt;
wire mclk_rise = mclk_sync & ~mclk_prev;
wire loss_max = (loss_cnt == `SRCD_MCLK_LOSS_CYC);

// Two-stage synchroniser, edge detect and loss timer
always @(posedge clock_i or negedge reset_n_i)
begin
  if (!reset_n_i)
  begin
    mclk_meta <= 1'b0;
    mclk_sync <= 1'b0;
    mclk_prev <= 1'b0;
    mclk_phase <= 1'b0;
    loss_cnt <= 12'h000;
    mclk_present_o <= 1'b0;
    core_tick_o <= 1'b0;
  end
  else
  begin
    mclk_meta <= mclk_i;
    mclk_sync <= mclk_meta;
    mclk_prev <= mclk_sync;
    if (mclk_rise)
    begin
      loss_cnt <= 12'h000;
      mclk_present_o <= 1'b1;
    end
    else if (!loss_max)
      loss_cnt <= loss_cnt + 12'h001;
    else
      mclk_present_o <= 1'b0;
    if (mclk_rise)
      mclk_phase <= ~mclk_phase;
    // Core tick on every master rising edge, or every second one when halving
    core_tick_o <= core_gate & mclk_rise & (~halving | mclk_phase);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Decoder outputs, refreshed every cycle from the fields

always @(posedge clock_i or negedge reset_n_i)
begin
  if (!reset_n_i)
  begin
    ratio <= 11'h000;
    mic_div <= 6'h00;
    mic_rate_ok <= 1'b0;
  end
  else
  begin
    ratio <= srcd_ratio(ratio_family, ratio_index);
    mic_div <= srcd_mic_div(ratio, srcd_fs_hz(rate_code));
    mic_rate_ok <= (rate_code < `SRCD_RATE_88K2);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Sample strobe and microphone clock dividers on core ticks

reg [10:0] fs_cnt;
reg [5:0] mic_cnt;
wire mic_run = pin_mic_sel & mic_rate_ok & (mic_div != 6'h00);

always @(posedge clock_i or negedge reset_n_i)
begin
  if (!reset_n_i)
  begin
    fs_cnt <= 11'h000;
    mic_cnt <= 6'h00;
    fs_tick_o <= 1'b0;
    ratio_o <= 11'h000;
    dsp_clock_on_o <= 1'b0;
    left_filter_on_o <= 1'b0;
    right_filter_on_o <= 1'b0;
    general_pin_one_o <= 1'b0;
    general_pin_one_oe_n_o <= 1'b1;
  end
  else
  begin
    ratio_o <= ratio;
    // One fs strobe serves the DAC and microphone paths alike
    fs_tick_o <= 1'b0;
    if (ratio == 11'h000)
      fs_cnt <= 11'h000;
    else if (core_tick_o)
    begin
      if (fs_cnt >= ratio - 11'h001)
      begin
        fs_cnt <= 11'h000;
        fs_tick_o <= 1'b1;
      end
      else
        fs_cnt <= fs_cnt + 11'h001;
    end
    dsp_clock_on_o <= core_gate & dsp_gate;
    left_filter_on_o <= core_gate & dsp_gate & left_on & mic_rate_ok;
    right_filter_on_o <= core_gate & dsp_gate & right_on & mic_rate_ok;
    // Mic clock high for the first half of each divisor period
    general_pin_one_oe_n_o <= ~pin_mic_sel;
    if (!mic_run)
    begin
      mic_cnt <= 6'h00;
      general_pin_one_o <= 1'b0;
    end
    else if (core_tick_o)
    begin
      if (mic_cnt >= mic_div - 6'h01)
        mic_cnt <= 6'h00;
      else
        mic_cnt <= mic_cnt + 6'h01;
      general_pin_one_o <= (mic_cnt < {1'b0, mic_div[5:1]});
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave

reg aw_held;
reg w_held;
reg [11:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire [7:0] w_idx = aw_addr[9:2];
wire w_hit = (aw_addr[11:10] == 2'h0) && (w_idx >= `SRCD_IDX_RATES0) && (w_idx <= `SRCD_IDX_STATUS);
// Access fails while gated with no master clock, except the enables register
wire w_block = core_gate & ~mclk_present_o & (w_idx != `SRCD_IDX_ENABLES);
wire [7:0] r_idx = s_axi_araddr_i[9:2];
wire r_hit = (s_axi_araddr_i[11:10] == 2'h0) && (r_idx >= `SRCD_IDX_RATES0) && (r_idx <= `SRCD_IDX_STATUS);
wire r_block = core_gate & ~mclk_present_o & (r_idx != `SRCD_IDX_ENABLES);
wire do_write = aw_held & w_held & ~s_axi_bvalid_o;
wire wr_ok = do_write & w_hit & ~w_block;
reg [31:0] r_word;

// Read data mux
always @*
begin
  r_word = 32'h0;
  case (r_idx)
    `SRCD_IDX_RATES0: r_word[`SRCD_HALVE_BIT] = halving;
    `SRCD_IDX_RATE_SEL: r_word = {18'h0, ratio_index, ratio_family, 4'h0, rate_code};
    `SRCD_IDX_ENABLES: r_word = {29'h0, core_gate, dsp_gate, 1'b0};
    `SRCD_IDX_MIC_CTRL: r_word = {29'h0, right_on, left_on, pin_mic_sel};
    `SRCD_IDX_STATUS: r_word = {5'h00, ratio, 2'h0, mic_div, 6'h00, mic_rate_ok, mclk_present_o};
    default: r_word = 32'h0;
  endcase
end

always @(posedge clock_i or negedge reset_n_i)
begin
  if (!reset_n_i)
  begin
    aw_held <= 1'b0;
    w_held <= 1'b0;
    aw_addr <= 12'h000;
    w_data <= 32'h0;
    w_strb <= 4'h0;
    s_axi_awready_o <= 1'b0;
    s_axi_wready_o <= 1'b0;
    s_axi_bvalid_o <= 1'b0;
    s_axi_bresp_o <= `SRCD_RESP_OKAY;
    s_axi_arready_o <= 1'b0;
    s_axi_rvalid_o <= 1'b0;
    s_axi_rdata_o <= 32'h0;
    s_axi_rresp_o <= `SRCD_RESP_OKAY;
    halving <= 1'b0;
    ratio_index <= `SRCD_RST_IDX;
    ratio_family <= `SRCD_RST_FAM;
    rate_code <= `SRCD_RST_RATE;
    core_gate <= 1'b0;
    dsp_gate <= 1'b0;
    pin_mic_sel <= 1'b0;
    left_on <= 1'b0;
    right_on <= 1'b0;
  end
  else
  begin
    // Address and data are taken independently, in either order
    s_axi_awready_o <= ~aw_held & ~(s_axi_awvalid_i & s_axi_awready_o) & ~s_axi_bvalid_o;
    s_axi_wready_o <= ~w_held & ~(s_axi_wvalid_i & s_axi_wready_o) & ~s_axi_bvalid_o;
    if (s_axi_awvalid_i & s_axi_awready_o)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i & s_axi_wready_o)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end
    if (do_write)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= !w_hit ? `SRCD_RESP_DECERR : (w_block ? `SRCD_RESP_SLVERR : `SRCD_RESP_OKAY);
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
    // Register updates, low byte lane then high byte lane
    if (wr_ok && w_strb[0])
    begin
      case (w_idx)
        `SRCD_IDX_RATES0: halving <= w_data[`SRCD_HALVE_BIT];
        `SRCD_IDX_RATE_SEL: rate_code <= w_data[`SRCD_RATE_HI:`SRCD_RATE_LO];
        `SRCD_IDX_ENABLES:
        begin
          core_gate <= w_data[`SRCD_GATE_BIT];
          dsp_gate <= w_data[`SRCD_DSP_BIT];
        end
        `SRCD_IDX_MIC_CTRL:
        begin
          pin_mic_sel <= w_data[`SRCD_PIN_BIT];
          left_on <= w_data[`SRCD_LEFT_BIT];
          right_on <= w_data[`SRCD_RIGHT_BIT];
        end
        default: halving <= halving;
      endcase
    end
    if (wr_ok && w_strb[1] && w_idx == `SRCD_IDX_RATE_SEL)
    begin
      ratio_index <= w_data[`SRCD_IDX_HI:`SRCD_IDX_LO];
      ratio_family <= w_data[`SRCD_FAM_HI:`SRCD_FAM_LO];
    end
    // Read channel
    s_axi_arready_o <= ~s_axi_rvalid_o & ~(s_axi_arvalid_i & s_axi_arready_o);
    if (s_axi_arvalid_i & s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= (r_hit & ~r_block) ? r_word : 32'h0;
      s_axi_rresp_o <= !r_hit ? `SRCD_RESP_DECERR : (r_block ? `SRCD_RESP_SLVERR : `SRCD_RESP_OKAY);
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end
end

endmodule // srcd_top

// ---- srcd_mclk_model.sv ----
// Master clock source model for the sample rate decoder
`timescale 1ns/100ps
module srcd_mclk_model
#(
  parameter HALF_NS = 40
)
(
  // Control
  input wire run_i,
  // Clock out
  output reg mclk_o
);
  // Toggle while running, park low once stopped
  initial
  begin
    mclk_o = 1'b0;
    forever
    begin
      #HALF_NS;
      if (run_i || mclk_o)
        mclk_o = ~mclk_o;
    end
  end
endmodule // srcd_mclk_model

// ---- srcd_chk_sva.sv ----
// Checker for bus answers and clock enables of the sample rate decoder
`timescale 1ns/100ps
module srcd_chk
(
  // Clock and reset
  input logic clock_i,
  input logic reset_n_i,
  input logic mclk_i,
  // Bus
  input logic s_axi_awvalid_i,
  input logic s_axi_awready_o,
  input logic s_axi_wvalid_i,
  input logic s_axi_wready_o,
  input logic s_axi_bvalid_o,
  input logic [1:0] s_axi_bresp_o,
  input logic s_axi_bready_i,
  input logic s_axi_arvalid_i,
  input logic s_axi_arready_o,
  input logic s_axi_rvalid_o,
  input logic [31:0] s_axi_rdata_o,
  input logic [1:0] s_axi_rresp_o,
  input logic s_axi_rready_i,
  // Enables
  input logic core_tick_o,
  input logic fs_tick_o,
  input logic [10:0] ratio_o,
  input logic mclk_present_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic mclk_q;
  logic [9:0] quiet;
  ////////////////////////////////////////////////////////////////////////////
  // Edges since the master clock pin last moved
  always @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      mclk_q <= 1'b0;
      quiet <= 10'h000;
    end
    else
    begin
      mclk_q <= mclk_i;
      if (mclk_i != mclk_q)
        quiet <= 10'h000;
      else if (quiet != 10'h3FF)
        quiet <= quiet + 10'h001;
    end
  ////////////////////////////////////////////////////////////////////////////
  // Bus answers
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  AST_W_ANSWER: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##[2:3] s_axi_bvalid_o)
    else $error("write response late");
  AST_R_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  AST_FAIL_ZERO: assert property (s_axi_rvalid_o && s_axi_rresp_o != 2'h0 |-> s_axi_rdata_o == 32'h0)
    else $error("failed read returns data");
  // Clock enables
  AST_TICK_PULSE: assert property (core_tick_o |=> !core_tick_o)
    else $error("core tick wider than one cycle");
  AST_NO_MCLK_TICK: assert property (($stable(mclk_i))[*6] |-> !core_tick_o)
    else $error("core tick without master clock");
  AST_MCLK_LOSS: assert property (quiet > 10'h104 |-> !mclk_present_o)
    else $error("master clock loss not seen");
  AST_FS_IDLE: assert property ((ratio_o == 11'h000)[*3] |-> !fs_tick_o)
    else $error("sample tick at reserved ratio");
  // Main scenarios
  COV_GATED: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
  COV_DECERR: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h3);
  COV_FS: cover property (fs_tick_o);
endmodule // srcd_chk
bind srcd_top srcd_chk i_chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .mclk_i(mclk_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rready_i(s_axi_rready_i), .core_tick_o(core_tick_o), .fs_tick_o(fs_tick_o),
  .ratio_o(ratio_o), .mclk_present_o(mclk_present_o));

// ---- tb.sv ----
// Self-checking testbench of the sample rate decoder
`timescale 1ns/100ps
`include "srcd_map.vh"
module tb;
  localparam [11:0] A_R0 = {`SRCD_IDX_RATES0, 2'b00};
  localparam [11:0] A_SEL = {`SRCD_IDX_RATE_SEL, 2'b00};
  localparam [11:0] A_EN = {`SRCD_IDX_ENABLES, 2'b00};
  localparam [11:0] A_MIC = {`SRCD_IDX_MIC_CTRL, 2'b00};
  logic clock_i, reset_n_i, run, mclk, awv, wv, br, arv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, d, wx;
  logic aw_rdy, w_rdy, bv, ar_rdy, rv, tick, fst, dsp, lf, rf, pres, pin, pin_oe_n;
  logic [1:0] bresp, rresp, r;
  logic [10:0] ratio;
  int n_errors = 0, n_tests = 0, n, nt, nc;
  logic [31:0] seed = 32'h0001_11E1;
  ////////////////////////////////////////////////////////////////////////////
  srcd_mclk_model #(.HALF_NS(40)) i_mclk (.run_i(run), .mclk_o(mclk));
  srcd_top i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .mclk_i(mclk),
    .s_axi_awvalid_i(awv), .s_axi_awaddr_i(awa), .s_axi_awready_o(aw_rdy), .s_axi_wvalid_i(wv),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wready_o(w_rdy), .s_axi_bvalid_o(bv),
    .s_axi_bresp_o(bresp), .s_axi_bready_i(br), .s_axi_arvalid_i(arv), .s_axi_araddr_i(ara),
    .s_axi_arready_o(ar_rdy), .s_axi_rvalid_o(rv), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
    .s_axi_rready_i(rr), .core_tick_o(tick), .fs_tick_o(fst), .ratio_o(ratio), .dsp_clock_on_o(dsp),
    .left_filter_on_o(lf), .right_filter_on_o(rf), .mclk_present_o(pres), .general_pin_one_o(pin),
    .general_pin_one_oe_n_o(pin_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  // Xorshift source, ratio table and checks
  function automatic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic [10:0] exp_ratio(input int f, input int i);
    int t[3][10] = '{'{64, 128, 192, 256, 384, 512, 768, 1024, 1408, 1536},
      '{68, 136, 204, 272, 408, 544, 816, 1088, 1496, 1632}, '{125, 125, 250, 250, 375, 500, 750, 1000, 1000, 1500}};
    return (f > 2 || i > 9) ? 11'h000 : t[f][i];
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    n_tests++;
    if (g < lo || g > hi)
    begin
      n_errors++;
      $display("MISMATCH %0t count %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // Bus master, answer taken on the ready edge, stall cycles before ready
  task automatic axi_wr(input [11:0] a, input [31:0] v, input int st, output [1:0] re);
    int c = 0;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= (st == 0);
    do
    begin
      @(posedge clock_i);
      c++;
      if (awv && aw_rdy) awv <= 1'b0;
      if (wv && w_rdy) wv <= 1'b0;
      if (c == st) br <= 1'b1;
    end
    while (!(bv && br));
    re = bresp;
    br <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic axi_rd(input [11:0] a, input int st, output [31:0] v, output [1:0] re);
    int c = 0;
    ara <= a;
    arv <= 1'b1;
    rr <= (st == 0);
    do
    begin
      @(posedge clock_i);
      c++;
      if (arv && ar_rdy) arv <= 1'b0;
      if (c == st) rr <= 1'b1;
    end
    while (!(rv && rr));
    v = rd;
    re = rresp;
    rr <= 1'b0;
    @(posedge clock_i);
  endtask
  // Core ticks and cycles between two rises of the sample tick or mic clock
  task automatic gap(input bit sel_pin);
    logic p, q = 1'b1;
    int e = 0;
    nt = 0;
    nc = 0;
    while (e < 2)
    begin
      @(posedge clock_i);
      p = sel_pin ? pin : fst;
      if (p && !q) e++;
      if (e == 1) nc++;
      if (e == 1) nt += tick;
      q = p;
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog, limit well above the expected 3000 cycles
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  initial
  begin
    #(8 * 40000);
    n_errors++;
    complete_run;
  end
  // Main sequence
  initial
  begin
    {reset_n_i, awv, wv, br, arv, rr, awa, ara, wd} = '0;
    run = 1'b1;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    axi_rd(A_SEL, 0, d, r);
    chk(d, 32'h0000_0C08);
    axi_rd(12'h7FC, 4, d, r);
    chk(r, `SRCD_RESP_DECERR);
    for (int f = 0; f < 4; f++)
      for (int i = 0; i < 11; i++)
      begin
        // Random rate up to 48k only, so the microphone rate stays legal for any index and family
        wx = (i << 10) | (f << 8) | (rnd() % 9);
        axi_wr(A_SEL, wx, i % 3 * 3, r);
        repeat (3) @(posedge clock_i);
        chk(ratio, exp_ratio(f, i));
        axi_rd(A_SEL, 0, d, r);
        chk(d, wx);
      end
    // Core gate on with the master clock running, filters need it
    axi_wr(A_EN, 32'h6, 0, r);
    chk(dsp, 1'b1);
    axi_wr(A_MIC, 32'h7, 0, r);
    for (int c = 0; c < 11; c++)
    begin
      // Filters off and ratio index 0001 before the two high rates
      if (c == 9) axi_wr(A_MIC, 32'h1, 0, r);
      axi_wr(A_SEL, (c < 9 ? 32'h0C00 : 32'h0400) | c, 0, r);
      repeat (3) @(posedge clock_i);
      chk({lf, rf}, c < 9 ? 2'h3 : 2'h0);
      if (c > 8) chk(pin, 1'b0);
    end
    chk(pin_oe_n, 1'b0);
    axi_wr(A_SEL, 32'h0C08, 0, r);
    axi_wr(A_EN, 32'h6, 0, r);
    for (int h = 1; h >= 0; h--)
    begin
      axi_wr(A_R0, h, 0, r);
      repeat (4) @(posedge clock_i);
      n = 0;
      repeat (400) @(posedge clock_i) n += tick;
      chk_rng(n, 40 / (h + 1) - 1, 40 / (h + 1) + 1);
    end
    gap(1);
    chk_rng(nc * 8, 334, 1000);
    chk(256 % nt, 0);
    axi_wr(A_SEL, 32'h0008, 0, r);
    gap(0);
    chk_rng(nt, 64, 64);
    run <= 1'b0;
    repeat (300) @(posedge clock_i);
    chk(pres, 1'b0);
    axi_wr(A_SEL, 32'h0401, 0, r);
    chk(r, `SRCD_RESP_SLVERR);
    axi_rd(A_SEL, 0, d, r);
    chk(r, `SRCD_RESP_SLVERR);
    axi_rd(A_EN, 0, d, r);
    chk({r, d}, {`SRCD_RESP_OKAY, 32'h6});
    axi_wr(A_EN, 32'h2, 0, r);
    chk(r, `SRCD_RESP_OKAY);
    chk(dsp, 1'b0);
    axi_rd(A_SEL, 0, d, r);
    chk({r, d}, {`SRCD_RESP_OKAY, 32'h8});
    complete_run;
  end
endmodule // tb
